//--- tb/remote_output_and_torque_flag_bench.sv
// self-checking bench for the host output and torque flag block
module remote_output_and_torque_flag_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [8:0]  t;
		logic [11:0] w1;
		logic [11:0] w2;
		logic [6:0]  base;
		logic [6:0]  ext;
		logic [2:0]  rly;
	} rotf_row_t;
	// torque and words in, expected terminals out
	rotf_row_t   rows [4] = '{
		'{9'h000, 12'h000, 12'h000, 7'h1a, 7'h02, 3'h0},
		'{9'h096, 12'hfff, 12'hfff, 7'h15, 7'h01, 3'h1},
		'{9'h095, 12'h001, 12'h080, 7'h1b, 7'h02, 3'h1},
		'{9'h190, 12'h002, 12'h003, 7'h14, 7'h01, 3'h0}
	};
	logic        clk = 1'b0;
	logic        srst, ce, stopped, nv_erase, ext_fit, rly_fit, wr_en, wr_ack, wr_err, busy, tflag;
	logic [1:0]  lock;
	logic [3:0]  ev;
	logic [4:0]  wr_sel, rd_sel;
	logic [11:0] wr_data, rdq;
	logic [8:0]  torque_est;
	logic [16:0] native;
	logic [6:0]  base, ext_out;
	logic [2:0]  rly_out;
	int          mismatches = 0;
	int          compares = 0;
	always #25 clk = ~clk;
	rotf_host_model host (.clk(clk), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data), .wr_ack(wr_ack));
	rotf_top uut (.clk(clk), .srst(srst), .ce(ce), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
		.wr_ack(wr_ack), .wr_err(wr_err), .rd_sel(rd_sel), .rd_data_q(rdq), .write_lock_select(lock),
		.drive_stopped(stopped), .power_down_pin(ev[0]), .power_up_pin(ev[1]), .reset_terminal_pin(ev[2]),
		.comm_reset_req(ev[3]), .nv_erase(nv_erase), .torque_est(torque_est), .native_fn_level(native),
		.ext_opt_fitted(ext_fit), .relay_opt_fitted(rly_fit), .torque_threshold_flag(tflag), .base_terms(base),
		.extension_outputs(ext_out), .relay_option_outputs(rly_out), .seq_busy(busy));
	task automatic report_and_stop();
		if (mismatches == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	task automatic cmp_val(input string what, input logic [11:0] exp, input logic [11:0] got);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [4:0] sel, input logic [11:0] data, input logic ok);
		host.write(sel, data);
		cmp_val("write accepted", {11'h000, ok}, {11'h000, host.took});
	endtask
	task automatic rd(input logic [4:0] sel, input logic [11:0] exp);
		@(posedge clk);
		rd_sel <= sel;
		repeat (2) @(posedge clk);
		#1;
		cmp_val("readback", exp, rdq);
	endtask
	task automatic tq(input logic [8:0] t, input logic f);
		@(posedge clk);
		torque_est <= t;
		repeat (3) @(posedge clk);
		#1;
		cmp_val("torque flag", {11'h000, f}, {11'h000, tflag});
		cmp_val("flag terminal", {11'h000, f}, {11'h000, base[2]});
	endtask
	// pin event, then a bounded wait for any save or load to finish
	task automatic evt(input logic [3:0] m);
		int n;
		@(posedge clk);
		ev <= m;
		@(posedge clk);
		ev <= 4'h0;
		repeat (5) @(posedge clk);
		#1;
		n = 0;
		while (busy === 1'b1 && n < 20) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (n == 20) begin
			mismatches++;
			report_and_stop();
		end
		repeat (2) @(posedge clk);
	endtask
	initial begin
		srst = 1'b1;
		ce = 1'b1;
		stopped = 1'b0;
		nv_erase = 1'b1;
		ext_fit = 1'b1;
		rly_fit = 1'b1;
		lock = 2'h2;
		ev = 4'h0;
		rd_sel = 5'h00;
		torque_est = 9'h000;
		native = 17'h00010;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		nv_erase <= 1'b0;
		rd(5'h01, 12'h000);
		rd(5'h02, 12'h000);
		rd(5'h03, 12'h096);
		wr(5'h04, 12'h060, 1'b1);
		wr(5'h05, 12'h0c4, 1'b1);
		wr(5'h06, 12'h023, 1'b1);
		wr(5'h07, 12'h087, 1'b1);
		wr(5'h0b, 12'h060, 1'b1);
		wr(5'h0c, 12'h0c4, 1'b1);
		wr(5'h12, 12'h060, 1'b1);
		foreach (rows[i]) begin
			wr(5'h01, rows[i].w1, 1'b1);
			wr(5'h02, rows[i].w2, 1'b1);
			tq(rows[i].t, rows[i].t >= 9'h096);
			cmp_val("base terminals", {5'h00, rows[i].base}, {5'h00, base});
			cmp_val("extension outputs", {5'h00, rows[i].ext}, {5'h00, ext_out});
			cmp_val("relay outputs", {9'h000, rows[i].rly}, {9'h000, rly_out});
		end
		// lock refuses the level but never the words
		@(posedge clk);
		lock <= 2'h1;
		wr(5'h03, 12'h0c8, 1'b0);
		wr(5'h01, 12'h001, 1'b1);
		// lock code 0: level writable only while the drive stands still
		lock <= 2'h0;
		wr(5'h03, 12'h0c8, 1'b0);
		stopped <= 1'b1;
		wr(5'h03, 12'h0c8, 1'b1);
		lock <= 2'h2;
		wr(5'h03, 12'h191, 1'b0);
		wr(5'h03, 12'h190, 1'b1);
		wr(5'h03, 12'h0c8, 1'b1);
		tq(9'h0c7, 1'b0);
		// clock enable low freezes the flag although the torque has risen
		@(posedge clk);
		ce <= 1'b0;
		torque_est <= 9'h0c8;
		repeat (3) @(posedge clk);
		#1;
		cmp_val("frozen flag", 12'h000, {11'h000, tflag});
		@(posedge clk);
		ce <= 1'b1;
		tq(9'h0c8, 1'b1);
		wr(5'h00, 12'h002, 1'b0);
		// drive reset clears, then holds; power loss clears
		wr(5'h00, 12'h000, 1'b1);
		evt(4'h4);
		rd(5'h01, 12'h000);
		cmp_val("run terminal", 12'h000, {11'h000, base[0]});
		wr(5'h00, 12'h00a, 1'b1);
		wr(5'h01, 12'h003, 1'b1);
		evt(4'h8);
		rd(5'h01, 12'h003);
		evt(4'h1);
		rd(5'h01, 12'h000);
		evt(4'h2);
		// save across power loss, then reload the saved words on drive reset
		wr(5'h00, 12'h00b, 1'b1);
		wr(5'h01, 12'h005, 1'b1);
		wr(5'h02, 12'h081, 1'b1);
		evt(4'h1);
		evt(4'h2);
		rd(5'h01, 12'h005);
		rd(5'h02, 12'h081);
		cmp_val("base terminals", 12'h017, {5'h00, base});
		wr(5'h00, 12'h001, 1'b1);
		wr(5'h01, 12'h00c, 1'b1);
		evt(4'h8);
		rd(5'h01, 12'h005);
		// options removed: their outputs go quiet whatever the word says
		@(posedge clk);
		ext_fit <= 1'b0;
		rly_fit <= 1'b0;
		repeat (3) @(posedge clk);
		#1;
		cmp_val("extension outputs", 12'h000, {5'h00, ext_out});
		cmp_val("relay outputs", 12'h000, {9'h000, rly_out});
		// mid-run power-on reset: words cleared, level back to its start value
		tq(9'h0a0, 1'b0);
		@(posedge clk);
		srst <= 1'b1;
		repeat (6) @(posedge clk);
		srst <= 1'b0;
		rd(5'h01, 12'h000);
		rd(5'h03, 12'h096);
		cmp_val("flag after reset", 12'h001, {11'h000, tflag});
		report_and_stop();
	end
endmodule

//--- tb/rotf_chk.sv
// port assertions for the host output and torque flag block
module rotf_chk (
	// clocking and reset
	input wire logic        clk,
	input wire logic        srst,
	input wire logic        ce,
	// write port
	input wire logic        wr_en,
	input wire logic [4:0]  wr_sel,
	input wire logic [11:0] wr_data,
	input wire logic        wr_ack,
	input wire logic        wr_err,
	// torque and options
	input wire logic [8:0]  torque_est,
	input wire logic        ext_opt_fitted,
	input wire logic        relay_opt_fitted,
	// outputs
	input wire logic        torque_threshold_flag,
	input wire logic [6:0]  extension_outputs,
	input wire logic [2:0]  relay_option_outputs,
	input wire logic        seq_busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [8:0] lvl_q;
	logic [8:0] lvl_d;
	// level shadow follows accepted writes only, so refused values never leak in
	always_comb begin
		lvl_d = lvl_q;
		if (ce && wr_en && wr_ack && wr_sel == 5'h03) begin
			lvl_d = wr_data[8:0];
		end
	end
	always_ff @(posedge clk) begin
		lvl_q <= srst ? 9'h096 : lvl_d;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	tflag_on_a: assert property (ce && torque_est >= lvl_q |=> torque_threshold_flag)
		else $error("torque flag low at or above level");
	tflag_off_a: assert property (ce && torque_est < lvl_q |=> !torque_threshold_flag)
		else $error("torque flag high below level");
	word_accept_a: assert property (wr_en && wr_sel inside {5'h01, 5'h02} |-> wr_ack && !wr_err)
		else $error("word write not accepted");
	retain_refuse_a: assert property (wr_en && wr_sel == 5'h00 &&
		!(wr_data inside {12'h000, 12'h001, 12'h00a, 12'h00b}) |-> wr_err && !wr_ack)
		else $error("bad retention value accepted");
	level_refuse_a: assert property (wr_en && wr_sel == 5'h03 && wr_data > 12'h190 |-> wr_err && !wr_ack)
		else $error("level above range accepted");
	ext_absent_a: assert property (!ext_opt_fitted |=> extension_outputs == 7'h00)
		else $error("extension outputs driven without option");
	relay_absent_a: assert property (!relay_opt_fitted |=> relay_option_outputs == 3'h0)
		else $error("relay outputs driven without option");
	busy_len_a: assert property ($rose(seq_busy) |-> seq_busy [*3] ##[1:2] !seq_busy)
		else $error("sequence busy length wrong");
	ack_idle_a: assert property (!wr_en |-> !wr_ack && !wr_err)
		else $error("write answer without request");
endmodule

bind rotf_top rotf_chk chk (.clk(clk), .srst(srst), .ce(ce), .wr_en(wr_en), .wr_sel(wr_sel), .wr_data(wr_data),
	.wr_ack(wr_ack), .wr_err(wr_err), .torque_est(torque_est), .ext_opt_fitted(ext_opt_fitted),
	.relay_opt_fitted(relay_opt_fitted), .torque_threshold_flag(torque_threshold_flag),
	.extension_outputs(extension_outputs), .relay_option_outputs(relay_option_outputs), .seq_busy(seq_busy));

//--- tb/rotf_host_model.sv
// host that writes parameters over the serial link, one word per request
module rotf_host_model (
	// clock
	input  wire logic        clk,
	// write port toward the device
	output logic             wr_en,
	output logic      [4:0]  wr_sel,
	output logic      [11:0] wr_data,
	input  wire logic        wr_ack
);
	timeunit 1ns;
	timeprecision 1ps;
	logic took;
	initial begin
		wr_en = 1'b0;
		wr_sel = 5'h00;
		wr_data = 12'h000;
		took = 1'b0;
	end
	// request held to the taking edge, answer taken there
	task automatic write(input logic [4:0] sel, input logic [11:0] data);
		@(posedge clk);
		wr_en <= 1'b1;
		wr_sel <= sel;
		wr_data <= data;
		@(posedge clk);
		took = wr_ack;
		wr_en <= 1'b0;
		// released lines show the inverse so a stale value cannot pass
		wr_sel <= ~sel;
		wr_data <= ~data;
	endtask
endmodule

//--- verilog/rotf_nv_store.sv
// small nonvolatile word store with registered read data
module rotf_nv_store #(
	parameter int WIDTH = 12,
	parameter int DEPTH = 4,
	parameter int AW    = 2
) (
	// clocking
	input  wire logic             clk,
	input  wire logic             ce,
	// whole-store erase, the only way contents change besides a write
	input  wire logic             erase,
	// single access port
	input  wire logic             we,
	input  wire logic [AW-1:0]    addr,
	input  wire logic [WIDTH-1:0] wdata,
	output logic      [WIDTH-1:0] rdata_q
);
	logic [WIDTH-1:0] mem_q [DEPTH];
	logic [WIDTH-1:0] mem_d [DEPTH];
	logic [WIDTH-1:0] rdata_d;

	// next contents; srst deliberately absent so words survive power cycling
	always_comb begin
		mem_d = mem_q;
		rdata_d = mem_q[addr];
		if (erase) begin
			for (int i = 0; i < DEPTH; i++) begin
				mem_d[i] = '0;
			end
			rdata_d = '0;
		end else if (we) begin
			mem_d[addr] = wdata;
		end
	end

	// storage and read register
	always_ff @(posedge clk) begin
		if (ce) begin
			mem_q <= mem_d;
			rdata_q <= rdata_d;
		end
	end
endmodule

//--- verilog/rotf_pkg.sv
// types shared by the host output and torque flag block
package rotf_pkg;
	typedef logic [11:0] rotf_word_t;
	typedef logic [7:0]  rotf_fsel_t;
	typedef logic [3:0]  rotf_retain_t;
	typedef enum logic [1:0] {st_idle, st_save, st_load} rotf_seq_t;
endpackage

//--- verilog/rotf_regs.svh
// constants for the host output and torque flag block
// Behaviour
// [RULE_01] torque flag on while estimated torque >= level; level 0..400, resets to 150
// [RULE_02] torque flag drops as soon as estimated torque falls below the level
// [RULE_03] select code 35 routes the torque flag to a terminal, 135 inverted
// [RULE_04] select code 96 makes a terminal host-driven, 196 inverted
// [RULE_05] host-driven terminal on for data bit 1, off for 0, swapped when inverted
// [RULE_06] both host data words are 12 bits, range 0..4095, reset to zero
// [RULE_07] word one bits 0..6 drive the seven base terminals; bits 7..11 free
// [RULE_08] word two: low seven bits to extensions, next three to relays, when fitted
// [RULE_09] terminal not host-driven ignores its data bit, follows its own function
// [RULE_10] retention and data words writable at any time, whatever the write lock
// [RULE_11] retention 0 or 10: power loss clears both words and host outputs
// [RULE_12] retention 1 or 11: words saved at power-off, restored at power recovery
// [RULE_13] drive reset clears both words; retention 10 or 11 holds them instead
// [RULE_14] retention 1: drive reset reloads the words saved at last power-off
// [RULE_15] host updates the words over the serial link or a communication option
// [RULE_16] outputs and torque compare registered; a word write reaches pins next cycle
`ifndef ROTF_REGS_SVH
`define ROTF_REGS_SVH

// parameter select codes on the write and read ports
`define ROTF_SEL_RETAIN   5'h00
`define ROTF_SEL_WORD1    5'h01
`define ROTF_SEL_WORD2    5'h02
`define ROTF_SEL_TLEVEL   5'h03
`define ROTF_SEL_FSEL0    5'h04
`define ROTF_SEL_STATUS   5'h1f

// terminal layout
`define ROTF_NUM_TERM     17
`define ROTF_NUM_BASE     7
`define ROTF_NUM_EXT      7
`define ROTF_NUM_RELAY    3

// function select codes
`define ROTF_FS_TORQUE    8'h23
`define ROTF_FS_TORQUE_N  8'h87
`define ROTF_FS_HOST      8'h60
`define ROTF_FS_HOST_N    8'hc4
`define ROTF_FS_INV_BASE  8'h64
`define ROTF_FS_MAX       8'hc7
`define ROTF_FS_RESET     8'h00

// retention settings
`define ROTF_RET_CLR      4'h0
`define ROTF_RET_PWR      4'h1
`define ROTF_RET_RST      4'ha
`define ROTF_RET_BOTH     4'hb

// torque level, percent
`define ROTF_TLEVEL_RESET 9'h096
`define ROTF_TLEVEL_MAX   9'h190

// write lock settings
`define ROTF_LOCK_STOPPED 2'h0
`define ROTF_LOCK_DENY    2'h1

// word reset and nonvolatile slots
`define ROTF_WORD_RESET   12'h000
`define ROTF_NV_RETAIN    2'h0
`define ROTF_NV_WORD1     2'h1
`define ROTF_NV_WORD2     2'h2
`define ROTF_NV_LAST      2'h3

`endif

//--- verilog/rotf_top.sv
// host-driven output terminals with torque threshold flag
`include "rotf_regs.svh"

module rotf_top (
	// clocking and reset
	input  wire logic                      clk,
	input  wire logic                      srst,
	input  wire logic                      ce,
	// parameter write port
	input  wire logic                      wr_en,
	input  wire logic [4:0]                wr_sel,
	input  wire logic [11:0]               wr_data,
	output logic                           wr_ack,
	output logic                           wr_err,
	// parameter readback
	input  wire logic [4:0]                rd_sel,
	output logic      [11:0]               rd_data_q,
	// write lock and drive state
	input  wire logic [1:0]                write_lock_select,
	input  wire logic                      drive_stopped,
	// power and reset events
	input  wire logic                      power_down_pin,
	input  wire logic                      power_up_pin,
	input  wire logic                      reset_terminal_pin,
	input  wire logic                      comm_reset_req,
	input  wire logic                      nv_erase,
	// torque estimate in percent
	input  wire logic [8:0]                torque_est,
	// levels of natively assigned functions, one per terminal
	input  wire logic [`ROTF_NUM_TERM-1:0] native_fn_level,
	// option fitting
	input  wire logic                      ext_opt_fitted,
	input  wire logic                      relay_opt_fitted,
	// terminal outputs
	output logic                           torque_threshold_flag,
	output logic      [`ROTF_NUM_BASE-1:0] base_terms,
	output logic      [`ROTF_NUM_EXT-1:0]  extension_outputs,
	output logic      [`ROTF_NUM_RELAY-1:0] relay_option_outputs,
	output logic                           seq_busy
);
	// select code decoding
	function automatic logic fs_is_host(input rotf_pkg::rotf_fsel_t code);
		return (code == `ROTF_FS_HOST) || (code == `ROTF_FS_HOST_N);
	endfunction

	function automatic logic fs_is_torque(input rotf_pkg::rotf_fsel_t code);
		return (code == `ROTF_FS_TORQUE) || (code == `ROTF_FS_TORQUE_N);
	endfunction

	function automatic logic fs_inverted(input rotf_pkg::rotf_fsel_t code);
		return code >= `ROTF_FS_INV_BASE;
	endfunction

	// retention decoding
	function automatic logic ret_valid(input rotf_pkg::rotf_retain_t r);
		return (r == `ROTF_RET_CLR) || (r == `ROTF_RET_PWR) || (r == `ROTF_RET_RST) || (r == `ROTF_RET_BOTH);
	endfunction

	function automatic logic ret_keeps_power(input rotf_pkg::rotf_retain_t r);
		return (r == `ROTF_RET_PWR) || (r == `ROTF_RET_BOTH);
	endfunction

	function automatic logic ret_keeps_reset(input rotf_pkg::rotf_retain_t r);
		return (r == `ROTF_RET_RST) || (r == `ROTF_RET_BOTH);
	endfunction

	// pin synchronisers: bit 0 power down, 1 power up, 2 reset terminal
	logic [2:0] sync1_q;
	logic [2:0] sync2_q;
	logic [2:0] prev_q;
	logic [2:0] pin_edge;

	// parameter state
	rotf_pkg::rotf_retain_t ret_q;
	rotf_pkg::rotf_retain_t ret_d;
	rotf_pkg::rotf_word_t   w1_q;
	rotf_pkg::rotf_word_t   w1_d;
	rotf_pkg::rotf_word_t   w2_q;
	rotf_pkg::rotf_word_t   w2_d;
	logic [8:0]             lvl_q;
	logic [8:0]             lvl_d;
	rotf_pkg::rotf_fsel_t   fs_q [`ROTF_NUM_TERM];
	rotf_pkg::rotf_fsel_t   fs_d [`ROTF_NUM_TERM];
	logic [4:0]             fs_idx;
	logic                   locked;

	// save/restore sequencer
	rotf_pkg::rotf_seq_t    seq_q;
	rotf_pkg::rotf_seq_t    seq_d;
	logic [1:0]             cnt_q;
	logic [1:0]             cnt_d;
	logic                   load_ret_q;
	logic                   load_ret_d;
	logic                   nv_we;
	logic [1:0]             nv_addr;
	rotf_pkg::rotf_word_t   nv_wdata;
	rotf_pkg::rotf_word_t   nv_rdata;
	logic [1:0]             cap_addr;

	// events
	logic                   pwr_down;
	logic                   pwr_up;
	logic                   drv_reset;

	// outputs
	logic                           tq_q;
	logic                           tq_d;
	logic [`ROTF_NUM_TERM-1:0]      term_q;
	logic [`ROTF_NUM_TERM-1:0]      term_d;
	logic [`ROTF_NUM_TERM-1:0]      host_bits;
	logic [11:0]                    rd_d;

	// two stages before anything looks at a pin; edge taken on the second stage
	always_ff @(posedge clk) begin
		if (srst) begin
			sync1_q <= 3'h0;
			sync2_q <= 3'h0;
			prev_q <= 3'h0;
		end else if (ce) begin
			sync1_q <= {reset_terminal_pin, power_up_pin, power_down_pin};
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
		end
	end

	assign pin_edge  = sync2_q & ~prev_q;
	assign pwr_down  = pin_edge[0];
	assign pwr_up    = pin_edge[1];
	assign drv_reset = pin_edge[2] | comm_reset_req;

	// lock only guards the torque level and select codes
	assign locked = (write_lock_select == `ROTF_LOCK_DENY) ||
	                ((write_lock_select == `ROTF_LOCK_STOPPED) && !drive_stopped);
	assign fs_idx = wr_sel - `ROTF_SEL_FSEL0;
	assign cap_addr = cnt_q - 2'h1;

	// save/restore sequencer next state
	always_comb begin
		seq_d = seq_q;
		cnt_d = cnt_q;
		load_ret_d = load_ret_q;
		nv_we = 1'b0;
		nv_addr = cnt_q;
		nv_wdata = `ROTF_WORD_RESET;
		case (seq_q)
			rotf_pkg::st_idle: begin
				cnt_d = 2'h0;
				if (pwr_down && ret_keeps_power(ret_q)) begin
					seq_d = rotf_pkg::st_save; // see [RULE_12]
				end else if (pwr_up) begin
					seq_d = rotf_pkg::st_load; // see [RULE_12]
					load_ret_d = 1'b1;
				end else if (drv_reset && (ret_q == `ROTF_RET_PWR)) begin
					seq_d = rotf_pkg::st_load; // see [RULE_14]
					load_ret_d = 1'b0;
				end
			end
			rotf_pkg::st_save: begin
				nv_we = 1'b1;
				case (cnt_q)
					`ROTF_NV_RETAIN: nv_wdata = {8'h00, ret_q};
					`ROTF_NV_WORD1:  nv_wdata = w1_q;
					default:         nv_wdata = w2_q;
				endcase
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == `ROTF_NV_WORD2) begin
					seq_d = rotf_pkg::st_idle;
				end
			end
			rotf_pkg::st_load: begin
				// read data lags the address by one cycle, hence the extra count
				cnt_d = cnt_q + 2'h1;
				if (cnt_q == `ROTF_NV_LAST) begin
					seq_d = rotf_pkg::st_idle;
				end
			end
			default: begin
				seq_d = rotf_pkg::st_idle;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			seq_q <= rotf_pkg::st_idle;
			cnt_q <= 2'h0;
			load_ret_q <= 1'b0;
		end else if (ce) begin
			seq_q <= seq_d;
			cnt_q <= cnt_d;
			load_ret_q <= load_ret_d;
		end
	end

	rotf_nv_store #(
		.WIDTH (12),
		.DEPTH (4),
		.AW    (2)
	) u_nv (
		.clk     (clk),
		.ce      (ce),
		.erase   (nv_erase),
		.we      (nv_we),
		.addr    (nv_addr),
		.wdata   (nv_wdata),
		.rdata_q (nv_rdata)
	);

	// parameter next values: host writes first, then restore and reset events
	always_comb begin
		ret_d = ret_q;
		w1_d = w1_q;
		w2_d = w2_q;
		lvl_d = lvl_q;
		fs_d = fs_q;
		wr_ack = 1'b0;
		wr_err = 1'b0;
		if (wr_en) begin
			case (wr_sel)
				`ROTF_SEL_RETAIN: begin
					if (ret_valid(wr_data[3:0]) && (wr_data[11:4] == 8'h00)) begin
						ret_d = wr_data[3:0]; // see [RULE_10]
						wr_ack = 1'b1;
					end else begin
						wr_err = 1'b1;
					end
				end
				`ROTF_SEL_WORD1: begin
					w1_d = wr_data; // see [RULE_06] [RULE_10] [RULE_15]
					wr_ack = 1'b1;
				end
				`ROTF_SEL_WORD2: begin
					w2_d = wr_data; // see [RULE_06] [RULE_10] [RULE_15]
					wr_ack = 1'b1;
				end
				`ROTF_SEL_TLEVEL: begin
					if (!locked && (wr_data <= {3'h0, `ROTF_TLEVEL_MAX})) begin
						lvl_d = wr_data[8:0]; // see [RULE_01]
						wr_ack = 1'b1;
					end else begin
						wr_err = 1'b1;
					end
				end
				default: begin
					if ((wr_sel >= `ROTF_SEL_FSEL0) && (fs_idx < 5'(`ROTF_NUM_TERM)) && !locked &&
					    (wr_data <= {4'h0, `ROTF_FS_MAX})) begin
						fs_d[fs_idx] = wr_data[7:0];
						wr_ack = 1'b1;
					end else begin
						wr_err = 1'b1;
					end
				end
			endcase
		end
		// restored words land over any write in the same cycle
		if ((seq_q == rotf_pkg::st_load) && (cnt_q != 2'h0)) begin
			case (cap_addr)
				`ROTF_NV_RETAIN: begin
					if (load_ret_q && ret_valid(nv_rdata[3:0])) begin
						ret_d = nv_rdata[3:0];
					end
				end
				`ROTF_NV_WORD1: begin
					if (load_ret_q && !ret_keeps_power(ret_q)) begin
						w1_d = `ROTF_WORD_RESET; // see [RULE_11]
					end else begin
						w1_d = nv_rdata; // see [RULE_12] [RULE_14]
					end
				end
				default: begin
					if (load_ret_q && !ret_keeps_power(ret_q)) begin
						w2_d = `ROTF_WORD_RESET; // see [RULE_11]
					end else begin
						w2_d = nv_rdata; // see [RULE_12] [RULE_14]
					end
				end
			endcase
		end
		// power loss without retention drops the words at once
		if (pwr_down && !ret_keeps_power(ret_q)) begin
			w1_d = `ROTF_WORD_RESET; // see [RULE_11]
			w2_d = `ROTF_WORD_RESET;
		end
		// drive reset: clear unless held; retention 1 reloads via the sequencer
		if (drv_reset && (seq_q == rotf_pkg::st_idle) && !ret_keeps_reset(ret_q)) begin
			w1_d = `ROTF_WORD_RESET; // see [RULE_13]
			w2_d = `ROTF_WORD_RESET;
		end
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			ret_q <= `ROTF_RET_CLR;
			w1_q <= `ROTF_WORD_RESET; // see [RULE_06]
			w2_q <= `ROTF_WORD_RESET;
			lvl_q <= `ROTF_TLEVEL_RESET; // see [RULE_01]
			for (int i = 0; i < `ROTF_NUM_TERM; i++) begin
				fs_q[i] <= `ROTF_FS_RESET;
			end
		end else if (ce) begin
			ret_q <= ret_d;
			w1_q <= w1_d;
			w2_q <= w2_d;
			lvl_q <= lvl_d;
			fs_q <= fs_d;
		end
	end

	// host bit per terminal: base from word one, extension and relays from word two
	assign host_bits = {w2_q[9:0], w1_q[6:0]}; // see [RULE_07] [RULE_08]

	// terminal levels and torque compare
	always_comb begin
		tq_d = torque_est >= lvl_q; // see [RULE_01] [RULE_02]
		for (int i = 0; i < `ROTF_NUM_TERM; i++) begin
			if (fs_is_host(fs_q[i])) begin
				term_d[i] = host_bits[i] ^ fs_inverted(fs_q[i]); // see [RULE_04] [RULE_05]
			end else if (fs_is_torque(fs_q[i])) begin
				term_d[i] = tq_q ^ fs_inverted(fs_q[i]); // see [RULE_03]
			end else begin
				term_d[i] = native_fn_level[i] ^ fs_inverted(fs_q[i]); // see [RULE_09]
			end
		end
		// an absent option has no terminal to drive
		if (!ext_opt_fitted) begin
			term_d[13:7] = 7'h00; // see [RULE_08]
		end
		if (!relay_opt_fitted) begin
			term_d[16:14] = 3'h0; // see [RULE_08]
		end
	end

	// readback shows stored settings and live state
	always_comb begin
		rd_d = 12'h000;
		case (rd_sel)
			`ROTF_SEL_RETAIN: rd_d = {8'h00, ret_q};
			`ROTF_SEL_WORD1:  rd_d = w1_q;
			`ROTF_SEL_WORD2:  rd_d = w2_q;
			`ROTF_SEL_TLEVEL: rd_d = {3'h0, lvl_q};
			`ROTF_SEL_STATUS: rd_d = {10'h000, seq_q != rotf_pkg::st_idle, tq_q};
			default: begin
				if ((rd_sel >= `ROTF_SEL_FSEL0) && ((rd_sel - `ROTF_SEL_FSEL0) < 5'(`ROTF_NUM_TERM))) begin
					rd_d = {4'h0, fs_q[rd_sel - `ROTF_SEL_FSEL0]};
				end
			end
		endcase
	end

	// output registers, one cycle after the settings they follow
	always_ff @(posedge clk) begin
		if (srst) begin
			tq_q <= 1'b0;
			term_q <= '0;
			rd_data_q <= 12'h000;
		end else if (ce) begin
			tq_q <= tq_d; // see [RULE_16]
			term_q <= term_d; // see [RULE_16]
			rd_data_q <= rd_d;
		end
	end

	assign torque_threshold_flag = tq_q;
	assign base_terms            = term_q[6:0];
	assign extension_outputs     = term_q[13:7];
	assign relay_option_outputs  = term_q[16:14];
	assign seq_busy              = seq_q != rotf_pkg::st_idle;
endmodule
